// ===== rtl/pmu_pins_pkg.sv
//==========================================================================
// What this block does
// - off mode, pin three high outside Off
// - in Off, pin three shows inverted bit 7
// - decode mode, pin three low while address matches
// - pin three decode may gate with I/O read
// - direct mode, pin one inverts bit 7
// - decode mode, pin one low on match, optionally gated
// - pin one drives only when direction selects output
// - write counts between bounds, A23-A20 zero
// - compare ignores A13-A0; bounds give upper bits
// - lower bound bit 0 enables hit counting
// - write activity passes only when mask enables
// - hit limit is two to the field value
// - hit counter clears on expiry or other activity
// - report activity when hit count reaches limit
// - trigger period selects 4, 8, 16, 32 s
// - slow duration selects 0.25 to 2 s
// - trigger enable and fast clock enable bits
// - status bits stick; any write clears all but sources still active
// - bit 7 records interrupt lines 2 to 15
// - bits 3-1 DMA 3-1; bit 0 DMA 5-7
// - bit 6 adapter or misc; 5 window; 4 keyboard
// - mode field chooses each pin's operation
package pmu_pins_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_PIN_THREE_CONTROL = 8'h95;
  localparam logic [7:0] IDX_WRITE_WINDOW_LOW = 8'h9a;
  localparam logic [7:0] IDX_WRITE_WINDOW_HIGH = 8'h9b;
  localparam logic [7:0] IDX_PIN_ONE_CONTROL = 8'h9c;
  localparam logic [7:0] IDX_RESERVED_FIXED_VALUE = 8'h9d;
  localparam logic [7:0] IDX_AUTO_SLOW_CONTROL = 8'h9f;
  localparam logic [7:0] IDX_ACTIVITY_FLAGS_ONE = 8'ha0;
  localparam logic [7:0] IDX_AUX_CONFIG = 8'hb0;
  localparam logic [7:0] IDX_AUX_MISC = 8'hb1;

  localparam logic [7:0] RST_REG = 8'h00;

  // aux_config and misc field positions
  localparam int unsigned CFG_PIN3_MODE_LSB = 0;
  localparam int unsigned CFG_PIN1_MODE_LSB = 2;
  localparam int unsigned CFG_PIN1_DIR_BIT = 4;
  localparam int unsigned CFG_MEMWR_MASK_BIT = 5;
  localparam int unsigned CFG_TRIG_EN_BIT = 6;
  localparam int unsigned CFG_HS_CLK_EN_BIT = 7;
  localparam int unsigned MISC_SOFT_AC_BIT = 5;

  // control register fields
  localparam int unsigned PIN_LEVEL_BIT = 7;
  localparam int unsigned HIT_COUNT_ENABLE_BIT = 0;

  typedef enum logic [1:0] {
    PIN_MODE_FIXED,
    PIN_MODE_IORD,
    PIN_MODE_DECODE,
    PIN_MODE_DECODE_ALT
  } pin_mode_e;

  // timing
  localparam longint unsigned CLK_KHZ = 200000;
  localparam longint unsigned TRIG_BASE_MS = 4000;
  localparam longint unsigned SLOW_BASE_MS = 250;
  localparam longint unsigned TRIG_BASE_CYC = TRIG_BASE_MS * CLK_KHZ;
  localparam longint unsigned SLOW_BASE_CYC = SLOW_BASE_MS * CLK_KHZ;

endpackage

// ===== rtl/pmu_activity_pin_control.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module pmu_activity_pin_control
  import pmu_pins_pkg::*;
#(
  parameter logic [32:0] TRIG_BASE_CYCLES = 33'(TRIG_BASE_CYC),
  parameter logic [32:0] SLOW_BASE_CYCLES = 33'(SLOW_BASE_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // system bus pins
  input wire logic [23:0] sys_addr_i,
  input wire logic mem_write_n_i,
  input wire logic io_read_n_i,
  // activity sources (pins, active high)
  input wire logic [15:2] irq_i,
  input wire logic [7:0] dma_req_i,
  input wire logic ac_adapter_i,
  input wire logic mapped_window_i,
  input wire logic keyboard_i,
  // power manager side
  input wire logic power_manager_off_i,
  input wire logic state_counter_expired_i,
  output logic [7:0] activity_pulse_o,
  output logic mem_write_activity_o,
  output logic trigger_enable_o,
  output logic hs_clk_enable_o,
  output logic [32:0] trigger_cycles_o,
  output logic [32:0] slow_cycles_o,
  // programmable pins
  output logic aux_pin_three_o,
  output logic aux_pin_one_o,
  output logic aux_pin_one_oe_o
);

  if (TRIG_BASE_CYCLES[32:30] != 3'h0 || SLOW_BASE_CYCLES[32:30] != 3'h0) begin : g_bad
    $error("base cycle count too large for the shifted period");
  end

  //========================================================================
  // input synchronisers
  //========================================================================
  localparam int unsigned SYNC_W = 24 + 2 + 14 + 8 + 3;
  logic [SYNC_W-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;

  always_comb begin
    sync1_nxt = {sys_addr_i, mem_write_n_i, io_read_n_i, irq_i, dma_req_i,
                 ac_adapter_i, mapped_window_i, keyboard_i};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= {{(SYNC_W-2-25){1'b0}}, 2'h3, 25'h0};
      sync2_r <= {{(SYNC_W-2-25){1'b0}}, 2'h3, 25'h0};
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  logic [23:0] addr_s;
  logic mem_wr_n_s, io_rd_n_s, ac_s, mms_s, kb_s;
  logic [15:2] irq_s;
  logic [7:0] dma_s;
  assign {addr_s, mem_wr_n_s, io_rd_n_s, irq_s, dma_s, ac_s, mms_s, kb_s} = sync2_r;

  //========================================================================
  // ahb-lite register access
  //========================================================================
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_idx_r, wr_idx_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [7:0] pin3_ctl_r, pin3_ctl_nxt, win_low_r, win_low_nxt;
  logic [7:0] win_high_r, win_high_nxt, pin1_ctl_r, pin1_ctl_nxt;
  logic [7:0] rsvd_r, rsvd_nxt, slow_ctl_r, slow_ctl_nxt;
  logic [7:0] flags_r, flags_nxt, cfg_r, cfg_nxt, misc_r, misc_nxt;
  logic addr_phase, addr_mapped;
  logic [7:0] req_idx, wdata;
  logic [7:0] src_lvl;

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign req_idx = haddr_i[9:2];
  assign addr_mapped = (haddr_i[31:10] == 22'h0) && (haddr_i[1:0] == 2'h0);
  assign wdata = hwdata_i[7:0];

  always_comb begin
    wr_pend_nxt = addr_phase && hwrite_i && addr_mapped;
    wr_idx_nxt = addr_phase ? req_idx : wr_idx_r;
    pin3_ctl_nxt = pin3_ctl_r;
    win_low_nxt = win_low_r;
    win_high_nxt = win_high_r;
    pin1_ctl_nxt = pin1_ctl_r;
    rsvd_nxt = rsvd_r;
    slow_ctl_nxt = slow_ctl_r;
    cfg_nxt = cfg_r;
    misc_nxt = misc_r;
    flags_nxt = flags_r;
    if (wr_pend_r) begin
      if (wr_idx_r == IDX_PIN_THREE_CONTROL) begin
        pin3_ctl_nxt = wdata;
      end else if (wr_idx_r == IDX_WRITE_WINDOW_LOW) begin
        win_low_nxt = wdata & 8'hfd;
      end else if (wr_idx_r == IDX_WRITE_WINDOW_HIGH) begin
        win_high_nxt = wdata & 8'hf7;
      end else if (wr_idx_r == IDX_PIN_ONE_CONTROL) begin
        pin1_ctl_nxt = wdata;
      end else if (wr_idx_r == IDX_RESERVED_FIXED_VALUE) begin
        rsvd_nxt = wdata;
      end else if (wr_idx_r == IDX_AUTO_SLOW_CONTROL) begin
        slow_ctl_nxt = wdata & 8'h0f;
      end else if (wr_idx_r == IDX_ACTIVITY_FLAGS_ONE) begin
        flags_nxt = 8'h00;
      end else if (wr_idx_r == IDX_AUX_CONFIG) begin
        cfg_nxt = wdata;
      end else if (wr_idx_r == IDX_AUX_MISC) begin
        misc_nxt = wdata & 8'h20;
      end
    end
    // a source active in the clearing cycle keeps its bit set
    flags_nxt = flags_nxt | src_lvl;
    // read mux uses next values so a read right after a write sees it
    hrdata_nxt = 32'h0;
    if (addr_phase && !hwrite_i && addr_mapped) begin
      if (req_idx == IDX_PIN_THREE_CONTROL) begin
        hrdata_nxt = {24'h0, pin3_ctl_nxt};
      end else if (req_idx == IDX_WRITE_WINDOW_LOW) begin
        hrdata_nxt = {24'h0, win_low_nxt};
      end else if (req_idx == IDX_WRITE_WINDOW_HIGH) begin
        hrdata_nxt = {24'h0, win_high_nxt};
      end else if (req_idx == IDX_PIN_ONE_CONTROL) begin
        hrdata_nxt = {24'h0, pin1_ctl_nxt};
      end else if (req_idx == IDX_RESERVED_FIXED_VALUE) begin
        hrdata_nxt = {24'h0, rsvd_nxt};
      end else if (req_idx == IDX_AUTO_SLOW_CONTROL) begin
        hrdata_nxt = {24'h0, slow_ctl_nxt};
      end else if (req_idx == IDX_ACTIVITY_FLAGS_ONE) begin
        hrdata_nxt = {24'h0, flags_nxt};
      end else if (req_idx == IDX_AUX_CONFIG) begin
        hrdata_nxt = {24'h0, cfg_nxt};
      end else if (req_idx == IDX_AUX_MISC) begin
        hrdata_nxt = {24'h0, misc_nxt};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_r <= 32'h0;
      pin3_ctl_r <= RST_REG;
      win_low_r <= RST_REG;
      win_high_r <= RST_REG;
      pin1_ctl_r <= RST_REG;
      rsvd_r <= RST_REG;
      slow_ctl_r <= RST_REG;
      flags_r <= RST_REG;
      cfg_r <= RST_REG;
      misc_r <= RST_REG;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_idx_r <= wr_idx_nxt;
      hrdata_r <= hrdata_nxt;
      pin3_ctl_r <= pin3_ctl_nxt;
      win_low_r <= win_low_nxt;
      win_high_r <= win_high_nxt;
      pin1_ctl_r <= pin1_ctl_nxt;
      rsvd_r <= rsvd_nxt;
      slow_ctl_r <= slow_ctl_nxt;
      flags_r <= flags_nxt;
      cfg_r <= cfg_nxt;
      misc_r <= misc_nxt;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  //========================================================================
  // activity sources and pulses
  //========================================================================
  logic [7:0] src_prev_r, src_prev_nxt, act_pulse_r, act_pulse_nxt;
  logic other_activity;

  always_comb begin
    src_lvl[7] = |irq_s;
    src_lvl[6] = ac_s || misc_r[MISC_SOFT_AC_BIT];
    src_lvl[5] = mms_s;
    src_lvl[4] = kb_s;
    src_lvl[3:1] = dma_s[3:1];
    src_lvl[0] = |dma_s[7:5];
    src_prev_nxt = src_lvl;
    act_pulse_nxt = src_lvl & ~src_prev_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_prev_r <= 8'h00;
      act_pulse_r <= 8'h00;
    end else begin
      src_prev_r <= src_prev_nxt;
      act_pulse_r <= act_pulse_nxt;
    end
  end

  assign other_activity = |act_pulse_nxt;
  assign activity_pulse_o = act_pulse_r;

  //========================================================================
  // memory write window and hit counter
  //========================================================================
  logic mwr_prev_r, mwr_prev_nxt, hit_pulse_r, hit_pulse_nxt;
  logic [7:0] hit_cnt_r, hit_cnt_nxt, hit_limit;
  logic in_range, write_start, qualified;
  logic [8:0] cnt_inc;

  assign write_start = mwr_prev_r && !mem_wr_n_s;
  // low bits below A14 take no part in the compare
  assign in_range = (addr_s[23:20] == 4'h0) &&
                    (addr_s[19:14] > win_low_r[7:2]) &&
                    (addr_s[19:14] < {win_high_r[7:4], 2'h0});
  assign qualified = write_start && in_range && win_low_r[HIT_COUNT_ENABLE_BIT] &&
                     cfg_r[CFG_MEMWR_MASK_BIT];
  assign hit_limit = 8'h01 << win_high_r[2:0];
  assign cnt_inc = {1'b0, hit_cnt_r} + 9'h001;

  always_comb begin
    mwr_prev_nxt = mem_wr_n_s;
    hit_cnt_nxt = hit_cnt_r;
    hit_pulse_nxt = 1'b0;
    // a clear in the same cycle as a write drops that write
    if (state_counter_expired_i || other_activity) begin
      hit_cnt_nxt = 8'h00;
    end else if (qualified) begin
      if (cnt_inc >= {1'b0, hit_limit}) begin
        hit_cnt_nxt = 8'h00;
        hit_pulse_nxt = 1'b1;
      end else begin
        hit_cnt_nxt = cnt_inc[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mwr_prev_r <= 1'b1;
      hit_cnt_r <= 8'h00;
      hit_pulse_r <= 1'b0;
    end else begin
      mwr_prev_r <= mwr_prev_nxt;
      hit_cnt_r <= hit_cnt_nxt;
      hit_pulse_r <= hit_pulse_nxt;
    end
  end

  assign mem_write_activity_o = hit_pulse_r;

  //========================================================================
  // auto low-speed timing
  //========================================================================
  logic [32:0] trig_cyc_r, trig_cyc_nxt, slow_cyc_r, slow_cyc_nxt;

  always_comb begin
    trig_cyc_nxt = TRIG_BASE_CYCLES << slow_ctl_r[1:0];
    slow_cyc_nxt = SLOW_BASE_CYCLES << slow_ctl_r[3:2];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_cyc_r <= 33'h0;
      slow_cyc_r <= 33'h0;
    end else begin
      trig_cyc_r <= trig_cyc_nxt;
      slow_cyc_r <= slow_cyc_nxt;
    end
  end

  assign trigger_cycles_o = trig_cyc_r;
  assign slow_cycles_o = slow_cyc_r;
  assign trigger_enable_o = cfg_r[CFG_TRIG_EN_BIT];
  assign hs_clk_enable_o = cfg_r[CFG_HS_CLK_EN_BIT];

  //========================================================================
  // programmable pins
  //========================================================================
  pin_mode_e mode3, mode1;
  logic match3, match1, pin3_r, pin3_nxt, pin1_r, pin1_nxt, io_rd;

  assign mode3 = pin_mode_e'(cfg_r[CFG_PIN3_MODE_LSB +: 2]);
  assign mode1 = pin_mode_e'(cfg_r[CFG_PIN1_MODE_LSB +: 2]);
  assign match3 = addr_s[9:3] == pin3_ctl_r[6:0];
  assign match1 = addr_s[9:3] == pin1_ctl_r[6:0];
  assign io_rd = !io_rd_n_s;

  always_comb begin
    case (mode3)
      PIN_MODE_FIXED: begin
        pin3_nxt = power_manager_off_i ? !pin3_ctl_r[PIN_LEVEL_BIT] : 1'b1;
      end
      PIN_MODE_IORD: begin
        pin3_nxt = !(match3 && io_rd);
      end
      default: begin
        pin3_nxt = !match3;
      end
    endcase
    case (mode1)
      PIN_MODE_FIXED: begin
        pin1_nxt = !pin1_ctl_r[PIN_LEVEL_BIT];
      end
      PIN_MODE_IORD: begin
        pin1_nxt = !(match1 && io_rd);
      end
      default: begin
        pin1_nxt = !match1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin3_r <= 1'b1;
      pin1_r <= 1'b1;
    end else begin
      pin3_r <= pin3_nxt;
      pin1_r <= pin1_nxt;
    end
  end

  assign aux_pin_three_o = pin3_r;
  assign aux_pin_one_o = pin1_r;
  // the pin is an input unless software turns it round
  assign aux_pin_one_oe_o = cfg_r[CFG_PIN1_DIR_BIT];

  //========================================================================
  // checks
  //========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pin3_high_on;
    (mode3 == PIN_MODE_FIXED && !power_manager_off_i) |=> aux_pin_three_o;
  endproperty
  a_pin3_high_on: assert property (p_pin3_high_on)
    else $error("pin three not high outside off");

  property p_pin3_off;
    (mode3 == PIN_MODE_FIXED && power_manager_off_i)
      |=> aux_pin_three_o == !$past(pin3_ctl_r[7]);
  endproperty
  a_pin3_off: assert property (p_pin3_off)
    else $error("pin three off level wrong");

  property p_pin3_decode;
    mode3[1] |=> aux_pin_three_o == !$past(addr_s[9:3] == pin3_ctl_r[6:0]);
  endproperty
  a_pin3_decode: assert property (p_pin3_decode)
    else $error("pin three decode wrong");

  property p_pin3_iord;
    (mode3 == PIN_MODE_IORD && match3 && !io_rd) |=> aux_pin_three_o;
  endproperty
  a_pin3_iord: assert property (p_pin3_iord)
    else $error("pin three low without io read");

  property p_pin1_direct;
    (mode1 == PIN_MODE_FIXED) |=> aux_pin_one_o != $past(pin1_ctl_r[7]);
  endproperty
  a_pin1_direct: assert property (p_pin1_direct)
    else $error("pin one direct level wrong");

  property p_pin1_decode;
    (mode1 != PIN_MODE_FIXED && !match1) |=> aux_pin_one_o;
  endproperty
  a_pin1_decode: assert property (p_pin1_decode)
    else $error("pin one low without match");

  property p_pin1_dir;
    (wr_pend_r && wr_idx_r == IDX_AUX_CONFIG)
      |=> aux_pin_one_oe_o == $past(hwdata_i[4]);
  endproperty
  a_pin1_dir: assert property (p_pin1_dir)
    else $error("pin one direction not taken from write");

  property p_hit_needs_enable;
    mem_write_activity_o |-> $past(win_low_r[0] && cfg_r[5] && in_range && write_start);
  endproperty
  a_hit_needs_enable: assert property (p_hit_needs_enable)
    else $error("write activity without enabled in-range write");

  property p_hit_limit;
    mem_write_activity_o |-> ({1'b0, $past(hit_cnt_r)} + 9'h001 >= {1'b0, $past(hit_limit)});
  endproperty
  a_hit_limit: assert property (p_hit_limit)
    else $error("write activity at wrong count");

  property p_hit_clear;
    state_counter_expired_i |=> hit_cnt_r == 8'h00 && !mem_write_activity_o;
  endproperty
  a_hit_clear: assert property (p_hit_clear)
    else $error("hit counter not cleared on expiry");

  property p_flag_sticky;
    (|irq_s) |=> flags_r[7] ##1 (flags_r[7] || $past(wr_pend_r));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("interrupt flag not set or not held");

  property p_flag_clear;
    (wr_pend_r && wr_idx_r == IDX_ACTIVITY_FLAGS_ONE && src_lvl == 8'h00)
      |=> flags_r == 8'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flags not cleared by write");

  property p_trig;
    1'b1 |=> trigger_cycles_o == (TRIG_BASE_CYCLES << $past(slow_ctl_r[1:0]));
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger period count wrong");

  property p_pulse_one;
    activity_pulse_o[4] |=> !activity_pulse_o[4];
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("activity pulse longer than one cycle");

  c_hit: cover property (mem_write_activity_o && win_high_r[2:0] == 3'h1);
  c_pin3_off_low: cover property (mode3 == PIN_MODE_FIXED && power_manager_off_i ##1
                                  !aux_pin_three_o);
  c_flag_clear: cover property (flags_r != 8'h00 ##1 flags_r == 8'h00);
  c_pin1_match: cover property (mode1 == PIN_MODE_DECODE ##1 !aux_pin_one_o);

endmodule

// ===== dv/sys_bus_model.sv
`timescale 1ns/1ps
//==========================================================================
// system bus side: address pins and command strobes
module sys_bus_model (
  input wire logic clk_i,
  output logic [23:0] sys_addr_o,
  output logic mem_write_n_o,
  output logic io_read_n_o
);
  initial begin
    sys_addr_o = 24'h000000;
    mem_write_n_o = 1'b1;
    io_read_n_o = 1'b1;
  end
  task automatic drive(input logic [23:0] a, input logic mw_n, input logic ior_n);
    @(posedge clk_i);
    sys_addr_o <= a;
    mem_write_n_o <= mw_n;
    io_read_n_o <= ior_n;
  endtask
  // strobe held four cycles so the two-flop sync always catches it
  task automatic mem_write(input logic [23:0] a);
    drive(a, 1'b0, 1'b1);
    repeat (3) @(posedge clk_i);
    drive(a, 1'b1, 1'b1);
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pmu_pins_pkg::*;
  localparam logic [32:0] TB = 33'h10;
  localparam logic [32:0] SB = 33'h4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp, ac = 1'b0, win = 1'b0, kb = 1'b0;
  logic pm_off = 1'b0, expd = 1'b0, mwa, trig_en, hs_en, pin3, pin1, oe1, mw_n, ior_n;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [23:0] sa;
  logic [15:2] irq = '0;
  logic [7:0] dma = 8'h00, apulse, seen = 8'h00;
  logic [32:0] trig_cyc, slow_cyc;
  int bad_count = 0, n_compared = 0, mw_cnt = 0, pcnt = 0;
  always #2.5 clk_i = ~clk_i;
  pmu_activity_pin_control #(.TRIG_BASE_CYCLES(TB), .SLOW_BASE_CYCLES(SB))
      pmu_activity_pin_control_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .sys_addr_i(sa),
    .mem_write_n_i(mw_n), .io_read_n_i(ior_n), .irq_i(irq), .dma_req_i(dma),
    .ac_adapter_i(ac), .mapped_window_i(win), .keyboard_i(kb), .power_manager_off_i(pm_off),
    .state_counter_expired_i(expd), .activity_pulse_o(apulse), .mem_write_activity_o(mwa),
    .trigger_enable_o(trig_en), .hs_clk_enable_o(hs_en), .trigger_cycles_o(trig_cyc),
    .slow_cycles_o(slow_cyc), .aux_pin_three_o(pin3), .aux_pin_one_o(pin1),
    .aux_pin_one_oe_o(oe1));
  sys_bus_model sys_bus_model_i (.clk_i(clk_i), .sys_addr_o(sa), .mem_write_n_o(mw_n),
    .io_read_n_o(ior_n));
  always @(posedge clk_i) begin
    if (mwa === 1'b1) mw_cnt <= mw_cnt + 1;
    if (apulse !== 8'h00) begin
      seen <= apulse;
      pcnt <= pcnt + 1;
    end
  end
  //========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 33'h0, {32'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ahb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    ahb(1'b0, idx, 32'h0);
    chk(nm, {25'h0, e}, {1'b0, rd});
  endtask
  task automatic pins(input logic e3, input logic e1);
    repeat (5) @(posedge clk_i);
    chk("pin3", e3, pin3);
    chk("pin1", e1, pin1);
  endtask
  task automatic memw(input logic [23:0] a);
    sys_bus_model_i.mem_write(a);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //========================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] ix [9] = '{8'h95, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9f, 8'ha0, 8'hb0, 8'hb1};
    logic [7:0] ew [9] = '{8'hff, 8'hfd, 8'hf7, 8'hff, 8'hff, 8'h0f, 8'h00, 8'hff, 8'h20};
    for (int i = 0; i < 9; i++) rdc("reset value", ix[i], RST_REG);
    for (int i = 0; i < 9; i++) begin
      wr(ix[i], 8'hff);
      rdc("readback", ix[i], ew[i]);
    end
    wr(8'h96, 8'hff);
    rdc("unmapped", 8'h96, 8'h00);
    for (int i = 0; i < 9; i++) wr(ix[i], 8'h00);
    wr(IDX_RESERVED_FIXED_VALUE, 8'h40);
    rdc("reserved", IDX_RESERVED_FIXED_VALUE, 8'h40);
    wr(IDX_ACTIVITY_FLAGS_ONE, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pins;
    wr(IDX_PIN_THREE_CONTROL, 8'h80);
    wr(IDX_PIN_ONE_CONTROL, 8'h80);
    wr(IDX_AUX_CONFIG, 8'h10);
    pins(1'b1, 1'b0);
    chk("oe", 1'b1, oe1);
    pm_off <= 1'b1;
    pins(1'b0, 1'b0);
    wr(IDX_PIN_THREE_CONTROL, 8'h00);
    wr(IDX_PIN_ONE_CONTROL, 8'h00);
    pins(1'b1, 1'b1);
    pm_off <= 1'b0;
    wr(IDX_PIN_THREE_CONTROL, 8'h2a);
    wr(IDX_PIN_ONE_CONTROL, 8'h2a);
    wr(IDX_AUX_CONFIG, 8'h0a);
    sys_bus_model_i.drive(24'h0f0157, 1'b1, 1'b1);
    pins(1'b0, 1'b0);
    chk("oe", 1'b0, oe1);
    sys_bus_model_i.drive(24'h000158, 1'b1, 1'b1);
    pins(1'b1, 1'b1);
    wr(IDX_AUX_CONFIG, 8'h0f);
    sys_bus_model_i.drive(24'h000150, 1'b1, 1'b1);
    pins(1'b0, 1'b0);
    wr(IDX_AUX_CONFIG, 8'h05);
    pins(1'b1, 1'b1);
    sys_bus_model_i.drive(24'h000150, 1'b1, 1'b0);
    pins(1'b0, 1'b0);
    sys_bus_model_i.drive(24'h000000, 1'b1, 1'b1);
    $display("test pins done");
  endtask
  task automatic t_timing;
    for (int e = 0; e < 4; e++) begin
      wr(IDX_AUTO_SLOW_CONTROL, {4'h0, e[1:0], 2'(3 - e)});
      repeat (2) @(posedge clk_i);
      chk("trigger", TB << (3 - e), trig_cyc);
      chk("slow", SB << e, slow_cyc);
    end
    wr(IDX_AUX_CONFIG, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("trig_en", 2'b10, {trig_en, hs_en});
    wr(IDX_AUX_CONFIG, 8'h80);
    repeat (2) @(posedge clk_i);
    chk("hs_en", 2'b01, {trig_en, hs_en});
    $display("test timing done");
  endtask
  task automatic src(input int k, input logic v);
    case (k)
      0: irq[2] <= v;
      1: dma[5] <= v;
      2: dma[2] <= v;
      3: ac <= v;
      4: kb <= v;
      5: win <= v;
      6: dma[0] <= v;
      default: irq[15] <= v;
    endcase
  endtask
  task automatic t_flags;
    logic [7:0] ex [8] = '{8'h80, 8'h01, 8'h04, 8'h40, 8'h10, 8'h20, 8'h00, 8'h80};
    int p0;
    for (int k = 0; k < 8; k++) begin
      p0 = pcnt;
      src(k, 1'b1);
      repeat (5) @(posedge clk_i);
      src(k, 1'b0);
      repeat (5) @(posedge clk_i);
      rdc("flags", IDX_ACTIVITY_FLAGS_ONE, ex[k]);
      chk("pulses", ex[k] != 8'h00, pcnt - p0);
      if (ex[k] != 8'h00) chk("pulse bits", ex[k], seen);
      wr(IDX_ACTIVITY_FLAGS_ONE, 8'h5a);
      rdc("cleared", IDX_ACTIVITY_FLAGS_ONE, 8'h00);
    end
    wr(IDX_AUX_MISC, 8'h20);
    wr(IDX_AUX_MISC, 8'h00);
    rdc("soft flag", IDX_ACTIVITY_FLAGS_ONE, 8'h40);
    wr(IDX_ACTIVITY_FLAGS_ONE, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_hits;
    wr(IDX_AUX_CONFIG, 8'h20);
    wr(IDX_WRITE_WINDOW_LOW, 8'h05);
    wr(IDX_WRITE_WINDOW_HIGH, 8'h11);
    memw(24'h008000);
    memw(24'h004000);
    memw(24'h010000);
    memw(24'h108000);
    chk("hits", 0, mw_cnt);
    memw(24'h00ffff);
    chk("hits", 1, mw_cnt);
    memw(24'h008000);
    expd <= 1'b1;
    @(posedge clk_i);
    expd <= 1'b0;
    memw(24'h008000);
    chk("hits", 1, mw_cnt);
    kb <= 1'b1;
    repeat (5) @(posedge clk_i);
    kb <= 1'b0;
    memw(24'h008000);
    chk("hits", 1, mw_cnt);
    memw(24'h008000);
    chk("hits", 2, mw_cnt);
    wr(IDX_WRITE_WINDOW_HIGH, 8'h17);
    repeat (127) memw(24'h008000);
    chk("hits", 2, mw_cnt);
    memw(24'h008000);
    chk("hits", 3, mw_cnt);
    wr(IDX_WRITE_WINDOW_HIGH, 8'h10);
    memw(24'h008000);
    chk("hits", 4, mw_cnt);
    wr(IDX_WRITE_WINDOW_LOW, 8'h04);
    memw(24'h008000);
    chk("hits", 4, mw_cnt);
    wr(IDX_WRITE_WINDOW_LOW, 8'h05);
    wr(IDX_AUX_CONFIG, 8'h00);
    memw(24'h008000);
    chk("hits", 4, mw_cnt);
    $display("test hits done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_pins;
    t_timing;
    t_flags;
    t_hits;
    end_sim;
  end
  // all scenarios need roughly 1500 cycles
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
endmodule
